// file: pkg/imul_defs.vh
// Encodings, field positions and timing counts of the multiply result unit.
`ifndef IMUL_DEFS_VH
`define IMUL_DEFS_VH

`define OP_HI            31
`define OP_LO            26
`define FN_HI            5
`define FN_LO            0
`define SA_HI            10
`define SA_LO            6
`define SRC_A_HI         25
`define SRC_A_LO         21
`define SRC_B_HI         20
`define SRC_B_LO         16
`define RD_HI            15
`define RD_LO            11

`define OPC_GROUP_ZERO   6'h00
`define OPC_GROUP_TWO    6'h1c
`define FN_LEGACY_MUL    6'h02
`define FN_SIGNED_PROD   6'h18
`define FN_UNSIGNED_PROD 6'h19
`define FN_COPY_UPPER    6'h11
`define FN_COPY_BOTTOM   6'h13
`define SA_LOW_WORD      5'h02
`define SA_HIGH_WORD     5'h03
`define SA_ZERO          5'h00

`define OPN_NONE         3'h0
`define OPN_LEGACY_MUL   3'h1
`define OPN_R6_MUL       3'h2
`define OPN_COPY_UPPER   3'h3
`define OPN_COPY_BOTTOM  3'h4

`define MUL_LATENCY      2'h2
`define PROD_RESET       32'h0000_0000

`endif

// file: hw/mul_decode.v
// Instruction decoder for the multiply and product-copy instructions.
`timescale 1ns/1ps
`include "imul_defs.vh"

module mul_decode (
  input  wire [31:0] instr,
  input  wire        release6,
  output reg  [2:0]  opn,
  output reg         want_high,
  output reg         is_signed,
  output reg         reserved
);
  wire [5:0] op = instr[`OP_HI:`OP_LO];
  wire [5:0] fn = instr[`FN_HI:`FN_LO];
  wire [4:0] sa = instr[`SA_HI:`SA_LO];

  always @* begin
    opn       = `OPN_NONE;
    want_high = 1'b0;
    is_signed = 1'b1;
    reserved  = 1'b0;
    if (op == `OPC_GROUP_TWO && fn == `FN_LEGACY_MUL &&
        sa == `SA_ZERO) begin
      if (release6)
        reserved = 1'b1;
      else
        opn = `OPN_LEGACY_MUL;
    end else if (op == `OPC_GROUP_ZERO) begin
      if ((fn == `FN_SIGNED_PROD || fn == `FN_UNSIGNED_PROD) &&
          (sa == `SA_LOW_WORD || sa == `SA_HIGH_WORD)) begin
        if (release6) begin
          opn       = `OPN_R6_MUL;
          want_high = (sa == `SA_HIGH_WORD);
          is_signed = (fn == `FN_SIGNED_PROD);
        end
      end else if (fn == `FN_COPY_UPPER || fn == `FN_COPY_BOTTOM) begin
        if (release6)
          reserved = 1'b1;
        else if (fn == `FN_COPY_UPPER)
          opn = `OPN_COPY_UPPER;
        else
          opn = `OPN_COPY_BOTTOM;
      end
    end
  end
endmodule // mul_decode

// file: hw/mul_core.v
// Two-stage 32x32 multiplier returning the full 64-bit product.
`timescale 1ns/1ps

module mul_core (
  input  wire        mclk,
  input  wire        rst_n,
  input  wire        start,
  input  wire [31:0] a,
  input  wire [31:0] b,
  input  wire        is_signed,
  output reg  [63:0] product,
  output reg         done
);
  reg  [32:0] a_x;
  reg  [32:0] b_x;
  reg         go;
  wire [65:0] full = $signed(a_x) * $signed(b_x);

  // Operands are widened by one bit so a single signed multiplier covers
  // both signednesses: sign or zero extension picks the meaning.
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      a_x     <= 33'h0_0000_0000;
      b_x     <= 33'h0_0000_0000;
      go      <= 1'b0;
      product <= 64'h0000_0000_0000_0000;
      done    <= 1'b0;
    end else begin
      go   <= start;
      done <= go;
      if (start) begin
        a_x <= {is_signed & a[31], a};
        b_x <= {is_signed & b[31], b};
      end
      if (go)
        product <= full[63:0];
    end
  end
endmodule // mul_core

// file: hw/integer_multiply_result_unit.v
// Integer multiply result unit with product registers and interlock.
`timescale 1ns/1ps
`include "imul_defs.vh"

// Contract
// - Copy-to-upper loads the full source register into the upper product.
// - Copy-to-bottom loads the full source register into bottom product.
// - Copy-to-upper after a pair result may leave bottom unpredictable.
// - Copy-to-bottom after a pair result may leave upper unpredictable.
// - No spacing needed between product register read and later write.
// - Release 6 has no product registers nor copy instructions.
// - Legacy multiply: group two, function 000010, bits 10..6 zero.
// - Legacy multiply writes low 32 bits of signed product.
// - Legacy multiply leaves product registers possibly unpredictable.
// - No multiply ever raises an arithmetic exception.
// - Release 6 family: group zero, 011000 signed, 011001 unsigned.
// - Bits 10..6 of 00010 select low word, 00011 high word.
// - Signed low multiply writes low 32 bits of signed product.
// - Signed high multiply writes high 32 bits of signed product.
// - Unsigned low multiply writes low 32 bits of unsigned product.
// - Unsigned high multiply writes high 32 bits of unsigned product.
// - Release 6 multiplies ignore operand bits above 31.
// - Readers of a pending destination stall until the result is written.
module integer_multiply_result_unit (
  input  wire        mclk,
  input  wire        rst_n,
  input  wire        release6,
  input  wire        issue_valid,
  input  wire [31:0] instr,
  input  wire [31:0] source_a_data,
  input  wire [31:0] source_b_data,
  input  wire        read_valid,
  input  wire [4:0]  read_index_a,
  input  wire [4:0]  read_index_b,
  output reg         issue_ready,
  output reg         gpr_write_en,
  output reg  [4:0]  gpr_write_index,
  output reg  [31:0] gpr_write_data,
  output reg  [31:0] upper_product_reg,
  output reg  [31:0] bottom_product_reg,
  output reg         reserved_instr,
  output reg         arith_exception,
  output reg         read_stall
);
  localparam ST_IDLE = 1'b0;
  localparam ST_BUSY = 1'b1;

  wire [2:0]  opn;
  wire        want_high;
  wire        is_signed;
  wire        reserved;
  wire [63:0] product;
  wire        done;
  reg         state;
  reg         pend_high;
  reg  [4:0]  pend_dest;
  wire        accept = issue_valid & issue_ready;
  wire        start = accept && (opn == `OPN_LEGACY_MUL ||
                                 opn == `OPN_R6_MUL);
  wire [4:0]  dest = instr[`RD_HI:`RD_LO];

  mul_decode u_decode (
    .instr     (instr),
    .release6  (release6),
    .opn       (opn),
    .want_high (want_high),
    .is_signed (is_signed),
    .reserved  (reserved)
  );

  // Only the low 32 bits of each operand are ever seen by the multiplier.
  mul_core u_core (
    .mclk      (mclk),
    .rst_n     (rst_n),
    .start     (start),
    .a         (source_a_data),
    .b         (source_b_data),
    .is_signed (is_signed),
    .product   (product),
    .done      (done)
  );

  function hits;
    input [4:0] idx;
    input [4:0] dst;
    begin
      hits = (idx == dst) && (dst != 5'h00);
    end
  endfunction

  // The stall is registered so it reaches the pipeline from a flop. It
  // covers the issue cycle and every busy cycle, the done cycle included,
  // because the result only reaches the register file after that cycle.
  reg next_stall;
  always @* begin
    next_stall = 1'b0;
    if (start && read_valid)
      next_stall = hits(read_index_a, dest) | hits(read_index_b, dest);
    else if (state == ST_BUSY && read_valid)
      next_stall = hits(read_index_a, pend_dest) |
                   hits(read_index_b, pend_dest);
  end

  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state              <= ST_IDLE;
      pend_high          <= 1'b0;
      pend_dest          <= 5'h00;
      issue_ready        <= 1'b1;
      gpr_write_en       <= 1'b0;
      gpr_write_index    <= 5'h00;
      gpr_write_data     <= `PROD_RESET;
      upper_product_reg  <= `PROD_RESET;
      bottom_product_reg <= `PROD_RESET;
      reserved_instr     <= 1'b0;
      arith_exception    <= 1'b0;
      read_stall         <= 1'b0;
    end else begin
      gpr_write_en    <= 1'b0;
      reserved_instr  <= accept & reserved;
      arith_exception <= 1'b0;
      read_stall      <= next_stall;
      case (state)
        ST_IDLE: begin
          if (start) begin
            state       <= ST_BUSY;
            issue_ready <= 1'b0;
            pend_dest   <= dest;
            // Legacy form is always the signed low word.
            pend_high   <= (opn == `OPN_R6_MUL) & want_high;
          end
          // Copies write one register and leave the other untouched,
          // which satisfies the unpredictable allowance trivially.
          if (accept && !release6) begin
            if (opn == `OPN_COPY_UPPER)
              upper_product_reg <= source_a_data;
            if (opn == `OPN_COPY_BOTTOM)
              bottom_product_reg <= source_a_data;
          end
        end
        ST_BUSY: begin
          if (done) begin
            state           <= ST_IDLE;
            issue_ready     <= 1'b1;
            gpr_write_en    <= 1'b1;
            gpr_write_index <= pend_dest;
            gpr_write_data  <= pend_high ? product[63:32]
                                         : product[31:0];
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end
endmodule // integer_multiply_result_unit

// file: dv/imul_props.sv
// Port checker for the multiply result unit.
`timescale 1ns/1ps
module imul_props (
  input logic        mclk,
  input logic        rst_n,
  input logic        release6,
  input logic        issue_valid,
  input logic [31:0] instr,
  input logic [31:0] source_a_data,
  input logic        read_valid,
  input logic [4:0]  read_index_a,
  input logic        issue_ready,
  input logic        gpr_write_en,
  input logic [4:0]  gpr_write_index,
  input logic [31:0] upper_product_reg,
  input logic [31:0] bottom_product_reg,
  input logic        reserved_instr,
  input logic        arith_exception,
  input logic        read_stall
);
  wire tk = issue_valid && issue_ready;
  wire z = instr[31:26] == 6'h00;
  wire cu = tk && z && instr[5:0] == 6'h11;
  wire cb = tk && z && instr[5:0] == 6'h13;
  wire lg = tk && instr[31:26] == 6'h1c && instr[10:0] == 11'h002;
  wire mu = tk && (release6 ? z && instr[5:1] == 5'h0c
                   && instr[10:7] == 4'h1 : lg);
  logic [4:0] pend;
  // Destination of the multiply in flight, for the interlock checks.
  always_ff @(posedge mclk or negedge rst_n)
    if (!rst_n)
      pend <= 5'h00;
    else if (mu)
      pend <= instr[15:11];
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  no_arith_flag_a:
    assert property (!arith_exception) else $error("arith flag");
  upper_copy_a:
    assert property (cu && !release6 |=>
      upper_product_reg == $past(source_a_data)) else $error("upper");
  bottom_copy_a:
    assert property (cb && !release6 |=>
      bottom_product_reg == $past(source_a_data)) else $error("bottom");
  r6_copy_inert_a:
    assert property ((cu || cb) && release6 |=> $stable(upper_product_reg)
      && $stable(bottom_product_reg)) else $error("r6 copy");
  reserved_pulse_a:
    assert property ((lg || cu || cb) && release6 |=> reserved_instr)
      else $error("reserved");
  write_timing_a:
    assert property (mu |=> !issue_ready [*2] ##1 (issue_ready &&
      gpr_write_en && gpr_write_index == pend)) else $error("timing");
  stall_hit_a:
    assert property (!issue_ready && read_valid && read_index_a == pend
      && pend != 5'h00 |=> read_stall) else $error("stall");
  legacy_keep_a:
    assert property (lg && !release6 |=> $stable(upper_product_reg))
      else $error("legacy upper");
endmodule // imul_props

bind integer_multiply_result_unit imul_props i_imul_props (
  .mclk, .rst_n, .release6, .issue_valid, .instr, .source_a_data,
  .read_valid, .read_index_a, .issue_ready, .gpr_write_en,
  .gpr_write_index, .upper_product_reg, .bottom_product_reg,
  .reserved_instr, .arith_exception, .read_stall);

// file: dv/reg_file_model.sv
// Register file of the pipeline that feeds operands to the unit.
`timescale 1ns/1ps
module reg_file_model (
  input  logic        mclk,
  input  logic        ld_en,
  input  logic [4:0]  ld_idx,
  input  logic [31:0] ld_data,
  input  logic        wb_en,
  input  logic [4:0]  wb_idx,
  input  logic [31:0] wb_data,
  input  logic [31:0] instr,
  output logic [31:0] src_a,
  output logic [31:0] src_b
);
  logic [31:0] mem [32];
  assign src_a = mem[instr[25:21]];
  assign src_b = mem[instr[20:16]];
  // The unit writes back here, so a later read sees its result.
  always @(posedge mclk) begin
    if (ld_en)
      mem[ld_idx] <= ld_data;
    if (wb_en)
      mem[wb_idx] <= wb_data;
  end
endmodule // reg_file_model

// file: dv/test_integer_multiply_result_unit.sv
// Self-checking bench for the multiply result unit.
`timescale 1ns/1ps
module test_integer_multiply_result_unit;
  logic        mclk = 0;
  logic        rst_n = 0;
  logic        release6 = 0;
  logic        issue_valid = 0;
  logic        read_valid = 0;
  logic        ld_en = 0;
  logic [4:0]  read_index_a = 5'h00;
  logic [4:0]  read_index_b = 5'h00;
  logic [4:0]  ld_idx = 5'h00;
  logic [31:0] instr = 32'h0000_0000;
  logic [31:0] ld_data = 32'h0000_0000;
  logic [31:0] seed = 32'hc1d8_cbc0;
  logic [31:0] corner [4];
  wire  [31:0] source_a_data, source_b_data, gpr_write_data;
  wire  [31:0] upper_product_reg, bottom_product_reg;
  wire  [4:0]  gpr_write_index;
  wire         issue_ready, gpr_write_en, reserved_instr;
  wire         arith_exception, read_stall;
  int          error_cnt = 0;
  int          num_checks = 0;

  integer_multiply_result_unit i_integer_multiply_result_unit (
    .mclk, .rst_n, .release6, .issue_valid, .instr, .source_a_data,
    .source_b_data, .read_valid, .read_index_a, .read_index_b,
    .issue_ready, .gpr_write_en, .gpr_write_index, .gpr_write_data,
    .upper_product_reg, .bottom_product_reg, .reserved_instr,
    .arith_exception, .read_stall);
  reg_file_model i_reg_file_model (
    .mclk, .ld_en, .ld_idx, .ld_data, .wb_en(gpr_write_en),
    .wb_idx(gpr_write_index), .wb_data(gpr_write_data), .instr,
    .src_a(source_a_data), .src_b(source_b_data));

  always #10 mclk = ~mclk;

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  function automatic logic [31:0] expect_word(logic [31:0] w,
                                              logic [31:0] a, logic [31:0] b);
    logic [63:0] p;
    p = w[5:0] == 6'h19 ? {32'h0, a} * {32'h0, b}
        : {{32{a[31]}}, a} * {{32{b[31]}}, b};
    return w[6] ? p[63:32] : p[31:0];
  endfunction

  task automatic check(logic [31:0] seen, logic [31:0] want);
    num_checks++;
    if (seen !== want) begin
      error_cnt++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask

  task automatic conclude();
    if (error_cnt == 0 && num_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic load(logic [4:0] i, logic [31:0] d);
    @(posedge mclk);
    ld_en <= 1;
    ld_idx <= i;
    ld_data <= d;
    @(posedge mclk);
    ld_en <= 0;
  endtask

  // Returns just after the edge that took the word; the read stays up
  // so that a busy cycle also presents a read of the destination.
  task automatic issue(logic [31:0] w);
    @(posedge mclk);
    issue_valid <= 1;
    instr <= w;
    read_valid <= 1;
    read_index_a <= w[15:11];
    read_index_b <= w[25:21];
    @(posedge mclk);
    while (issue_ready !== 1'b1)
      @(posedge mclk);
    issue_valid <= 0;
    #1;
  endtask

  task automatic run(logic [31:0] w, logic [31:0] a, logic [31:0] b);
    int n;
    load(5'h01, a);
    load(5'h02, b);
    issue(w);
    check(read_stall, w[15:11] != 5'h00);
    n = 0;
    while (gpr_write_en !== 1'b1 && n < 6) begin
      @(posedge mclk);
      read_valid <= (n == 0);
      #1;
      n++;
    end
    check(n, 2);
    check(read_stall, w[15:11] != 5'h00);
    check(gpr_write_data, expect_word(w, a, b));
    check(gpr_write_index, w[15:11]);
  endtask

  initial begin
    logic [31:0] k;
    logic [31:0] cv;
    corner = '{32'h8000_0000, 32'hffff_ffff, 32'h7fff_ffff, 32'h0000_0001};
    repeat (2) @(posedge mclk);
    rst_n <= 1;
    run({6'h1c, 10'h022, 5'h05, 11'h002}, corner[0], corner[1]);
    cv = rnd();
    load(5'h03, cv);
    issue({6'h00, 5'h03, 15'h0000, 6'h11});
    check(upper_product_reg, cv);
    issue({6'h00, 5'h03, 15'h0000, 6'h13});
    check(bottom_product_reg, cv);
    run({6'h1c, 10'h022, 5'h06, 11'h002}, rnd(), rnd());
    check(upper_product_reg, cv);
    check(bottom_product_reg, cv);
    @(posedge mclk);
    release6 <= 1;
    for (int i = 0; i < 24; i++) begin
      k = i < 8 ? i : rnd();
      run({16'h0022, 1'b1, k[5:2], 4'h1, k[0], 5'h0c, k[1]},
          i < 8 ? corner[(i / 2) % 4] : rnd(),
          i < 8 ? corner[(i / 2 + 1) % 4] : rnd());
    end
    load(5'h03, ~cv);
    issue({6'h1c, 10'h022, 5'h05, 11'h002});
    check(reserved_instr, 1'b1);
    issue({6'h00, 5'h03, 15'h0000, 6'h11});
    check(reserved_instr, 1'b1);
    check(upper_product_reg, cv);
    issue({6'h00, 5'h03, 15'h0000, 6'h13});
    check(bottom_product_reg, cv);
    conclude();
  end

  initial begin
    #50000;
    error_cnt++;
    conclude();
  end
endmodule // test_integer_multiply_result_unit
